//--- sfi_master.sv
// Serial bus master model for the frame slave
`default_nettype none
module sfi_master (
  input wire logic clk_i,
  input wire logic so_i,
  output var logic sclk_o,
  output var logic cs_b_o,
  output var logic si_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock low
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
  end
  // One access of n bits; sel low leaves select high
  task automatic xfer(input int n, input logic [23:0] d, input bit sel,
                      output logic [23:0] q);
    q = '0;
    cs_b_o <= ~sel;
    repeat (10) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      si_o <= d[i];
      sclk_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      q = {q[22:0], so_i};
      sclk_o <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
    repeat (5) @(posedge clk_i);
    cs_b_o <= 1'b1;
    si_o <= ~si_o;
    repeat (10) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- sfi_pkg.sv
// Package and two-flop synchroniser for the serial frame slave
`default_nettype none

package sfi_pkg;
  localparam int unsigned FRAME_W = 8;
  localparam int unsigned CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [FRAME_W-1:0] FRAME_ZERO = 8'h00;
  // Fixed answer after a faulty transfer; arbitrary pattern
  localparam logic [FRAME_W-1:0] ERR_RESP = 8'h00_A5;
  localparam int unsigned MSB = FRAME_W - 1;
  // Decoded command frame handed to the device core
  typedef struct packed {
    logic valid;
    logic [FRAME_W-1:0] data;
  } sfi_cmd_t;
  localparam sfi_cmd_t CMD_IDLE = '{valid: 1'b0, data: FRAME_ZERO};
endpackage

////////////////////////////////////////////////////////////////////////////////

module sfi_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output var logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // Two stages, first read only by the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

`default_nettype wire

//--- sfi_slave.sv
// Serial frame slave: shift register, bit counter and frame check
// What this block does
// - While select is high, clock and input are ignored and output floats.
// - Input bits are taken on clock falls, output changes on clock rises.
// - At select rise a command is decoded only after a nonzero multiple of 8 pulses, else the error flag is set.
// - At select fall the pending answer is loaded into the shift register.
// - At select fall the output starts driving the level seen on the input.
// - At select rise after a good transfer the frame is handed over on cmd_o for one cycle.
// - Bits travel most significant first in both directions.
// - One 8 bit shift register takes one bit per clock and shows the bit leaving at the output.
// - The answer to a command comes in the following transfer.
// - After a faulty transfer the next answer is a fixed error frame.
`default_nettype none

module sfi_slave (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic si_i,
  input wire logic [sfi_pkg::FRAME_W-1:0] resp_data_i,
  output var logic so_o,
  output var logic so_oe_o,
  output var sfi_pkg::sfi_cmd_t cmd_o,
  output var logic transfer_error_flag_o
);
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_b_s;
  logic si_s;
  logic sclk_prev_q;
  logic cs_b_prev_q;
  logic [sfi_pkg::FRAME_W-1:0] shreg_q;
  logic [sfi_pkg::FRAME_W-1:0] shreg_d;
  logic [sfi_pkg::CNT_W-1:0] cnt_q;
  logic [sfi_pkg::CNT_W-1:0] cnt_d;
  logic any_q;
  logic any_d;
  logic bad_open_q;
  logic bad_open_d;
  logic so_d;
  logic so_oe_d;
  logic err_d;
  sfi_pkg::sfi_cmd_t cmd_d;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, select resets to deselected
  sfi_sync #(
    .W(3),
    .RST_VAL(3'h1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({si_i, sclk_i, cs_b_i}),
    .q_o(pins_s)
  );
  assign cs_b_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign si_s = pins_s[2];

  // Edge decode on the synchronised pins
  wire selected = !cs_b_s && !cs_b_prev_q;
  wire cs_fall = !cs_b_s && cs_b_prev_q;
  wire cs_rise = cs_b_s && !cs_b_prev_q;
  wire sclk_fall = selected && sclk_prev_q && !sclk_s;
  wire sclk_rise = selected && !sclk_prev_q && sclk_s;
  wire sclk_high = sclk_s || sclk_prev_q;

  // Whole-byte check at close of access
  wire frame_good = any_q && (cnt_q == sfi_pkg::CNT_ZERO)
                    && !bad_open_q && !sclk_high;

  // Answer chosen at open of access
  wire [sfi_pkg::FRAME_W-1:0] load_val = transfer_error_flag_o ?
    sfi_pkg::ERR_RESP : resp_data_i;

  //////////////////////////////////////////////////////////////////////////////
  // Shift register: MSB leaves first, new bit enters at LSB
  assign shreg_d = cs_fall ? load_val :
                   sclk_fall ? {shreg_q[sfi_pkg::MSB-1:0], si_s} :
                   shreg_q;

  // Modulo-8 pulse counter, cleared at open
  assign cnt_d = cs_fall ? sfi_pkg::CNT_ZERO :
                 sclk_fall ? cnt_q + sfi_pkg::CNT_ONE : cnt_q;
  assign any_d = cs_fall ? 1'b0 : (any_q || sclk_fall);
  assign bad_open_d = cs_fall ? sclk_high : bad_open_q;

  // Output pin: float when deselected, follow input at open
  assign so_oe_d = cs_fall ? 1'b1 : (cs_b_s ? 1'b0 : so_oe_o);
  assign so_d = cs_fall ? si_s :
                sclk_rise ? shreg_q[sfi_pkg::MSB] :
                so_o;

  // Command hand-over and error flag
  assign cmd_d = '{valid: cs_rise && frame_good, data: shreg_q};
  assign err_d = (cs_rise && !frame_good) ? 1'b1 :
                 cs_fall ? 1'b0 : transfer_error_flag_o;

  //////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_prev_q <= 1'b0;
      cs_b_prev_q <= 1'b1;
      shreg_q <= sfi_pkg::FRAME_ZERO;
      cnt_q <= sfi_pkg::CNT_ZERO;
      any_q <= 1'b0;
      bad_open_q <= 1'b0;
    end else if (ce_i) begin
      sclk_prev_q <= sclk_s;
      cs_b_prev_q <= cs_b_s;
      shreg_q <= shreg_d;
      cnt_q <= cnt_d;
      any_q <= any_d;
      bad_open_q <= bad_open_d;
    end
  end

  // Output registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      cmd_o <= sfi_pkg::CMD_IDLE;
      transfer_error_flag_o <= 1'b0;
    end else if (ce_i) begin
      so_o <= so_d;
      so_oe_o <= so_oe_d;
      cmd_o <= cmd_d;
      transfer_error_flag_o <= err_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_idle_float: assert property (
    ce_i && cs_b_s && cs_b_prev_q |=> !so_oe_o)
    else $error("output driven while deselected");
  a_open_drive: assert property (
    ce_i && cs_fall |=> so_oe_o && so_o == $past(si_s))
    else $error("output not driving input level at open");
  a_open_load: assert property (
    ce_i && cs_fall |=> shreg_q == $past(load_val))
    else $error("answer not loaded at open");
  a_err_answer: assert property (
    ce_i && cs_fall && transfer_error_flag_o |=>
    shreg_q == sfi_pkg::ERR_RESP && !transfer_error_flag_o)
    else $error("error answer not loaded");
  a_shift_in: assert property (
    ce_i && sclk_fall |=>
    shreg_q == {$past(shreg_q[sfi_pkg::MSB-1:0]), $past(si_s)})
    else $error("input bit not shifted in");
  a_rise_out: assert property (
    ce_i && sclk_rise |=> so_o == $past(shreg_q[sfi_pkg::MSB]))
    else $error("output bit wrong after clock rise");
  a_cnt_clear: assert property (
    ce_i && cs_fall |=> cnt_q == sfi_pkg::CNT_ZERO && !any_q)
    else $error("counter not cleared at open");
  a_good_decode: assert property (
    ce_i && cs_rise && frame_good |=>
    cmd_o.valid && cmd_o.data == $past(shreg_q) ##1 !cmd_o.valid)
    else $error("good frame not handed over once");
  a_bad_frame: assert property (
    ce_i && cs_rise && !frame_good |=>
    transfer_error_flag_o && !cmd_o.valid)
    else $error("faulty frame not flagged");

  c_good_frame: cover property (ce_i && cs_rise && frame_good);
  c_bad_frame: cover property (ce_i && cs_rise && !frame_good);
  c_err_reload: cover property (ce_i && cs_fall && transfer_error_flag_o);
endmodule

`default_nettype wire

//--- testbench.sv
// Self-checking bench for the serial frame slave
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sclk, cs_b, si, so, so_oe, err_flag;
  logic [7:0] resp = 8'h3C;
  logic [7:0] last_data;
  logic [23:0] got;
  sfi_pkg::sfi_cmd_t cmd;
  int bad_count = 0;
  int num_checks = 0;
  int pulses = 0;
  int cycles = 0;
  initial forever #4 clk_i = ~clk_i;
  sfi_slave sfi_slave_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .sclk_i(sclk), .cs_b_i(cs_b), .si_i(si), .resp_data_i(resp),
    .so_o(so), .so_oe_o(so_oe), .cmd_o(cmd),
    .transfer_error_flag_o(err_flag));
  sfi_master sfi_master_inst (.clk_i(clk_i), .so_i(so), .sclk_o(sclk),
    .cs_b_o(cs_b), .si_o(si));
  // Strobe counter and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (cmd.valid === 1'b1) begin
      pulses++;
      last_data = cmd.data;
    end
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [23:0] seen,
                       input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One or two bytes; n is the byte count, one strobe expected
  task automatic t_good(input int n, input logic [23:0] d,
                        input logic [23:0] e);
    int p;
    p = pulses;
    sfi_master_inst.xfer(n * 8, d, 1'b1, got);
    check("answer", got, e);
    check("strobes", 24'(pulses - p), 24'h00_0001);
    check("data", 24'(last_data), 24'(d[7:0]));
    check("flag", 24'(err_flag), 24'h00_0000);
    check("oe off", 24'(so_oe), 24'h00_0000);
    $display("test good %0d done", n);
  endtask
  // Wrong counts, then the fixed answer
  task automatic t_bad();
    int p;
    int lens [3] = '{0, 7, 9};
    foreach (lens[k]) begin
      p = pulses;
      sfi_master_inst.xfer(lens[k], 24'h00_01FF, 1'b1, got);
      check("bad strobes", 24'(pulses - p), 24'h00_0000);
      check("bad flag", 24'(err_flag), 24'h00_0001);
      sfi_master_inst.xfer(8, 24'h00_0081, 1'b1, got);
      check("err answer", got, 24'(sfi_pkg::ERR_RESP));
      check("flag clear", 24'(err_flag), 24'h00_0000);
    end
    $display("test bad done");
  endtask
  // Clock and data while deselected
  task automatic t_idle();
    int p;
    p = pulses;
    sfi_master_inst.xfer(8, 24'h00_00F0, 1'b0, got);
    check("idle strobes", 24'(pulses - p), 24'h00_0000);
    check("idle oe", 24'(so_oe), 24'h00_0000);
    $display("test idle done");
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_good(1, 24'h00_0096, 24'h00_003C);
    t_good(2, 24'h00_C35A, 24'h00_3CC3);
    t_bad();
    t_idle();
    end_sim();
  end
endmodule
`default_nettype wire
